// ---- logic/acq_completion_ctrl.sv ----
// acquisition mode, decimation and record completion control
`timescale 1ns/1ps
`include "acq_defs.svh"
module acq_completion_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // acquisition events
  input wire logic acq_trig,
  input wire logic acq_cycle_end,
  input wire logic single_run,
  // raw sample stream
  input wire logic smp_valid,
  input wire logic signed [15:0] smp_data,
  input wire logic [7:0] smp_bucket,
  // record storage
  output logic store_valid,
  output logic [7:0] store_addr,
  output logic signed [15:0] store_data,
  // peak column storage
  output logic peak_valid,
  output logic [7:0] peak_addr,
  output logic signed [15:0] peak_min,
  output logic signed [15:0] peak_max,
  output logic signed [15:0] peak_rnd,
  output logic signed [15:0] peak_eq,
  // status
  output logic meas_req,
  output logic record_complete,
  output logic sinc_smoothing_enable
);
  acq_pkg::acq_mode_type mode_ff;
  acq_pkg::acq_state_type st_ff;
  logic state_en_ff;
  logic interp_ff;
  logic avg_on_ff;
  logic [6:0] pct_ff;
  logic [15:0] ratio_ff;
  logic [12:0] avgc_ff;
  logic [8:0] rlen_ff;
  logic [7:0] clr_idx_ff;
  logic [8:0] full_cnt_ff;
  logic [7:0] col_ff;
  logic meas_req_ff;
  logic complete_ff;
  logic [31:0] rdata_ff;
  logic store_valid_ff;
  logic [7:0] store_addr_ff;
  logic signed [15:0] store_data_ff;
  logic [12:0] hit_mem [0:255];
  // ============================================================
  // decoding helpers
  function automatic logic mode_ok(input logic [2:0] m);
    mode_ok = (m <= `ACQ_MODE_MAX);
  endfunction
  function automatic logic rt_sampling(input acq_pkg::acq_mode_type m);
    rt_sampling = (m == acq_pkg::MODE_RT_NORMAL) || (m == acq_pkg::MODE_PEAK)
      || (m == acq_pkg::MODE_AVERAGE);
  endfunction
  function automatic logic decimating(input acq_pkg::acq_mode_type m);
    decimating = (m == acq_pkg::MODE_PEAK) || (m == acq_pkg::MODE_AVERAGE);
  endfunction
  // ============================================================
  // mode and condition decode
  logic realtime_normal_mode;
  logic equiv_time_mode;
  logic peak_capture_mode;
  logic averaging_resolution_mode;
  logic segmented_mode;
  logic running;
  logic eff_state;
  logic [12:0] target;
  logic [12:0] hit_cur;
  logic in_rec;
  logic col_ok;
  logic et_hit;
  logic crit_met;
  logic ev_cycle;
  logic et_done;
  logic meas_nxt;
  logic ctrl_wr;
  logic mode_chg;
  logic pk_in;
  logic av_in;
  logic rt_in;
  logic [15:0] rate_div;
  logic pk_valid;
  logic av_valid;
  logic signed [15:0] av_data;
  assign realtime_normal_mode = (mode_ff == acq_pkg::MODE_RT_NORMAL);
  assign equiv_time_mode = (mode_ff == acq_pkg::MODE_EQUIV);
  assign peak_capture_mode = (mode_ff == acq_pkg::MODE_PEAK);
  assign averaging_resolution_mode = (mode_ff == acq_pkg::MODE_AVERAGE);
  assign segmented_mode = (mode_ff == acq_pkg::MODE_SEGMENTED);
  assign running = (st_ff == acq_pkg::ST_RUN);
  assign eff_state = state_en_ff | single_run;
  assign target = avg_on_ff ? avgc_ff : 13'h0001;
  assign hit_cur = hit_mem[smp_bucket];
  assign in_rec = ({1'b0, smp_bucket} < rlen_ff);
  assign col_ok = ({1'b0, col_ff} < rlen_ff);
  assign et_hit = equiv_time_mode && running && smp_valid && in_rec && (hit_cur < target);
  assign crit_met = (16'(full_cnt_ff) * `ACQ_PCT_SCALE) >= (16'(pct_ff) * 16'(rlen_ff));
  assign ev_cycle = acq_cycle_end && running;
  assign et_done = equiv_time_mode && ev_cycle && eff_state && crit_met;
  assign meas_nxt = ev_cycle && (!equiv_time_mode || !eff_state || crit_met);
  assign ctrl_wr = reg_wr && (reg_addr == `ACQ_ADDR_CTRL);
  assign mode_chg = ctrl_wr && mode_ok(reg_wdata[2:0]) && (reg_wdata[2:0] != mode_ff);
  assign pk_in = peak_capture_mode && running && smp_valid && col_ok;
  assign av_in = averaging_resolution_mode && running && smp_valid && col_ok;
  assign rt_in = (realtime_normal_mode || segmented_mode) && running && smp_valid && col_ok;
  assign rate_div = decimating(mode_ff) ? ratio_ff : 16'h0001;
  // ============================================================
  // control register
  always_ff @(posedge clk)
    if (!rstn)
    begin
      mode_ff <= acq_pkg::MODE_RT_NORMAL;
      state_en_ff <= 1'b1;
      interp_ff <= 1'b0;
      avg_on_ff <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      if (mode_ok(reg_wdata[2:0]))
        mode_ff <= acq_pkg::acq_mode_type'(reg_wdata[2:0]);
      state_en_ff <= reg_wdata[`ACQ_CTRL_STATE];
      interp_ff <= reg_wdata[`ACQ_CTRL_INTERP];
      avg_on_ff <= reg_wdata[`ACQ_CTRL_AVG];
    end
  // ============================================================
  // completion percentage
  always_ff @(posedge clk)
    if (!rstn)
      pct_ff <= `ACQ_PCT_RST;
    else if (ctrl_wr && reg_wdata[`ACQ_CTRL_AUTO])
      pct_ff <= `ACQ_PCT_MAX;
    else if (reg_wr && (reg_addr == `ACQ_ADDR_PCT) && (reg_wdata <= {25'h0, `ACQ_PCT_MAX}))
      pct_ff <= reg_wdata[6:0];
  // ============================================================
  // decimation ratio, averaging count, record length
  always_ff @(posedge clk)
    if (!rstn)
    begin
      ratio_ff <= `ACQ_RATIO_RST;
      avgc_ff <= `ACQ_AVGC_RST;
      rlen_ff <= `ACQ_RLEN_RST;
    end
    else if (reg_wr)
    begin
      if ((reg_addr == `ACQ_ADDR_RATIO) && (reg_wdata[31:16] == 16'h0000)
        && (reg_wdata[15:0] != 16'h0000))
        ratio_ff <= reg_wdata[15:0];
      if ((reg_addr == `ACQ_ADDR_AVGC) && (reg_wdata[31:13] == 19'h00000)
        && (reg_wdata[12:0] >= `ACQ_AVGC_MIN) && (reg_wdata[12:0] <= `ACQ_AVGC_MAX))
        avgc_ff <= reg_wdata[12:0];
      if ((reg_addr == `ACQ_ADDR_RLEN) && (reg_wdata[31:9] == 23'h000000)
        && (reg_wdata[8:0] != 9'h000) && (reg_wdata[8:0] <= `ACQ_RLEN_MAX))
        rlen_ff <= reg_wdata[8:0];
    end
  // ============================================================
  // record state machine
  always_ff @(posedge clk)
    if (!rstn)
    begin
      st_ff <= acq_pkg::ST_CLEAR;
      clr_idx_ff <= 8'h00;
    end
    else
    begin
      case (st_ff)
        acq_pkg::ST_CLEAR:
        begin
          clr_idx_ff <= clr_idx_ff + 8'h01;
          if (clr_idx_ff == `ACQ_LAST_BUCKET)
            st_ff <= acq_pkg::ST_RUN;
        end
        acq_pkg::ST_RUN:
        begin
          clr_idx_ff <= 8'h00;
          if (et_done || mode_chg)
            st_ff <= acq_pkg::ST_CLEAR;
        end
        default:
        begin
          st_ff <= acq_pkg::ST_CLEAR;
          clr_idx_ff <= 8'h00;
        end
      endcase
    end
  // ============================================================
  // bucket hit memory and full count
  always_ff @(posedge clk)
    if (st_ff == acq_pkg::ST_CLEAR)
      hit_mem[clr_idx_ff] <= 13'h0000;
    else if (et_hit)
      hit_mem[smp_bucket] <= hit_cur + 13'h0001;
  always_ff @(posedge clk)
    if (!rstn)
      full_cnt_ff <= 9'h000;
    else if (st_ff == acq_pkg::ST_CLEAR)
      full_cnt_ff <= 9'h000;
    else if (et_hit && (hit_cur + 13'h0001 == target))
      full_cnt_ff <= full_cnt_ff + 9'h001;
  // ============================================================
  // column address within one trigger
  always_ff @(posedge clk)
    if (!rstn)
      col_ff <= 8'h00;
    else if (acq_trig)
      col_ff <= 8'h00;
    else if (rt_in || pk_valid || av_valid)
      col_ff <= col_ff + 8'h01;
  // ============================================================
  // decimators
  acq_peak_pick u_acq_peak_pick (
    .clk(clk),
    .rstn(rstn),
    .start(acq_trig),
    .in_valid(pk_in),
    .in_data(smp_data),
    .ratio(ratio_ff),
    .out_valid(pk_valid),
    .out_min(peak_min),
    .out_max(peak_max),
    .out_rnd(peak_rnd),
    .out_eq(peak_eq)
  );
  acq_region_avg u_acq_region_avg (
    .clk(clk),
    .rstn(rstn),
    .start(acq_trig),
    .in_valid(av_in),
    .in_data(smp_data),
    .ratio(ratio_ff),
    .out_valid(av_valid),
    .out_avg(av_data)
  );
  assign peak_valid = pk_valid;
  assign peak_addr = col_ff;
  // ============================================================
  // record storage writes
  always_ff @(posedge clk)
    if (!rstn)
    begin
      store_valid_ff <= 1'b0;
      store_addr_ff <= 8'h00;
      store_data_ff <= 16'h0000;
    end
    else if (equiv_time_mode && running && smp_valid && in_rec)
    begin
      store_valid_ff <= 1'b1;
      store_addr_ff <= smp_bucket;
      store_data_ff <= smp_data;
    end
    else if (rt_in)
    begin
      store_valid_ff <= 1'b1;
      store_addr_ff <= col_ff;
      store_data_ff <= smp_data;
    end
    else if (av_valid)
    begin
      store_valid_ff <= 1'b1;
      store_addr_ff <= col_ff;
      store_data_ff <= av_data;
    end
    else
      store_valid_ff <= 1'b0;
  // ============================================================
  // measurement request and completion flag
  always_ff @(posedge clk)
    if (!rstn)
      meas_req_ff <= 1'b0;
    else
      meas_req_ff <= meas_nxt;
  always_ff @(posedge clk)
    if (!rstn)
      complete_ff <= 1'b0;
    else if (meas_nxt)
      complete_ff <= 1'b1;
    else if (acq_trig)
      complete_ff <= 1'b0;
  // ============================================================
  // register readback
  always_ff @(posedge clk)
    if (!rstn)
      rdata_ff <= 32'h00000000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `ACQ_ADDR_CTRL: rdata_ff <= {26'h0, avg_on_ff, interp_ff, state_en_ff, mode_ff};
        `ACQ_ADDR_PCT: rdata_ff <= {25'h0, pct_ff};
        `ACQ_ADDR_RATIO: rdata_ff <= {16'h0000, ratio_ff};
        `ACQ_ADDR_AVGC: rdata_ff <= {19'h0, avgc_ff};
        `ACQ_ADDR_RLEN: rdata_ff <= {23'h0, rlen_ff};
        `ACQ_ADDR_STAT:
          rdata_ff <= {7'h00, full_cnt_ff, 13'h0, sinc_smoothing_enable, eff_state, complete_ff};
        `ACQ_ADDR_ERAT: rdata_ff <= {16'h0000, rate_div};
        default: rdata_ff <= 32'h00000000;
      endcase
    end
    else
      rdata_ff <= 32'h00000000;
  // ============================================================
  // outputs
  assign reg_rdata = rdata_ff;
  assign store_valid = store_valid_ff;
  assign store_addr = store_addr_ff;
  assign store_data = store_data_ff;
  assign meas_req = meas_req_ff;
  assign record_complete = complete_ff;
  assign sinc_smoothing_enable = interp_ff && rt_sampling(mode_ff);
  // ============================================================
  // assertions
  sequence s_et_crit;
    equiv_time_mode && ev_cycle && eff_state && crit_met;
  endsequence
  sequence s_et_restart;
    meas_req && (st_ff == acq_pkg::ST_CLEAR);
  endsequence
  property p_pct_range;
    @(posedge clk) disable iff (!rstn) pct_ff <= `ACQ_PCT_MAX;
  endproperty
  a_pct_range: assert property (p_pct_range) else $error("percent out of range");
  property p_pct_read;
    @(posedge clk) disable iff (!rstn)
      reg_rd && (reg_addr == `ACQ_ADDR_PCT) |=> reg_rdata == {25'h0, $past(pct_ff)};
  endproperty
  a_pct_read: assert property (p_pct_read) else $error("percent readback wrong");
  property p_crit_done;
    @(posedge clk) disable iff (!rstn) s_et_crit |=> s_et_restart;
  endproperty
  a_crit_done: assert property (p_crit_done) else $error("complete record not taken");
  property p_rt_meas;
    @(posedge clk) disable iff (!rstn) ev_cycle && !equiv_time_mode |=> meas_req;
  endproperty
  a_rt_meas: assert property (p_rt_meas) else $error("real-time cycle not measured");
  property p_single_hold;
    @(posedge clk) disable iff (!rstn)
      single_run && equiv_time_mode && ev_cycle && !crit_met |=> !meas_req;
  endproperty
  a_single_hold: assert property (p_single_hold) else $error("single run not forced");
  property p_off_meas;
    @(posedge clk) disable iff (!rstn)
      equiv_time_mode && ev_cycle && !eff_state && !mode_chg
      |=> meas_req && (st_ff == acq_pkg::ST_RUN);
  endproperty
  a_off_meas: assert property (p_off_meas) else $error("state off handling wrong");
  property p_sinc_et;
    @(posedge clk) disable iff (!rstn)
      ctrl_wr && (reg_wdata[2:0] == acq_pkg::MODE_EQUIV) |=> !sinc_smoothing_enable;
  endproperty
  a_sinc_et: assert property (p_sinc_et) else $error("filter on outside real time");
  property p_zero_pct;
    @(posedge clk) disable iff (!rstn)
      (pct_ff == 7'h00) && ev_cycle && equiv_time_mode |=> meas_req;
  endproperty
  a_zero_pct: assert property (p_zero_pct) else $error("zero percent not one cycle");
  property p_autoset;
    @(posedge clk) disable iff (!rstn)
      ctrl_wr && reg_wdata[`ACQ_CTRL_AUTO] |=> (pct_ff == `ACQ_PCT_MAX);
  endproperty
  a_autoset: assert property (p_autoset) else $error("autoset percent wrong");
  property p_peak_src;
    @(posedge clk) disable iff (!rstn) peak_valid |-> $past(pk_in && peak_capture_mode);
  endproperty
  a_peak_src: assert property (p_peak_src) else $error("peak column without samples");
endmodule

// ---- logic/acq_defs.svh ----
// constants of the acquisition decimation and completion block
`ifndef ACQ_DEFS_SVH
`define ACQ_DEFS_SVH
// ============================================================
// Summary of operation
// - completion percentage accepts and reports only integers 0 through 100
// - with completion state on, the percentage decides when acquisition completes
// - real-time sampling ignores completion state; each trigger fills the record
// - equivalent-time trigger may add no new points without harm
// - single capture forces completion state on; programmed value kept
// - completion state off measures after every acquisition cycle
// - completion state off keeps record; points overwritten only by new samples
// - interpolation enable acts only in real-time modes; reads back as 1 or 0
// - five sampling modes: normal, equivalent, peak, segmented, averaging
// - real-time normal captures the whole record from one trigger
// - equivalent time builds the record over several triggers
// - peak and averaging sample at full rate, all points in one trigger
// - samples per region equal sampling rate over storage rate
// - peak capture picks four samples per region per time column
// - picks are minimum, maximum, random and equally spaced samples
// - peak capture discards all other samples of the region
// - averaging mode stores the mean of each region
// - peak and averaging report and apply the storage rate
// - bucket full after one hit, or after averaging count when averaging
// - percentage zero completes after exactly one acquisition cycle
// - reset gives 90 percent; automatic setup sets 100 percent
// ============================================================
// register offsets
`define ACQ_ADDR_CTRL 4'h0
`define ACQ_ADDR_PCT 4'h1
`define ACQ_ADDR_RATIO 4'h2
`define ACQ_ADDR_AVGC 4'h3
`define ACQ_ADDR_RLEN 4'h4
`define ACQ_ADDR_STAT 4'h5
`define ACQ_ADDR_ERAT 4'h6
// control field positions
`define ACQ_CTRL_STATE 3
`define ACQ_CTRL_INTERP 4
`define ACQ_CTRL_AVG 5
`define ACQ_CTRL_AUTO 7
// reset and limit values
`define ACQ_PCT_RST 7'h5A
`define ACQ_PCT_MAX 7'h64
`define ACQ_PCT_SCALE 16'h0064
`define ACQ_RATIO_RST 16'h0004
`define ACQ_AVGC_RST 13'h0002
`define ACQ_AVGC_MIN 13'h0002
`define ACQ_AVGC_MAX 13'h1000
`define ACQ_RLEN_RST 9'h100
`define ACQ_RLEN_MAX 9'h100
`define ACQ_MODE_MAX 3'h4
`define ACQ_LAST_BUCKET 8'hFF
`define ACQ_LFSR_SEED 16'hACE1
`define ACQ_LFSR_TAPS 16'hB400
`endif

// ---- logic/acq_peak_pick.sv ----
// peak capture decimator: four picks per data region
`timescale 1ns/1ps
`include "acq_defs.svh"
module acq_peak_pick (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // sample stream
  input wire logic start,
  input wire logic in_valid,
  input wire logic signed [15:0] in_data,
  input wire logic [15:0] ratio,
  // picked column
  output logic out_valid,
  output logic signed [15:0] out_min,
  output logic signed [15:0] out_max,
  output logic signed [15:0] out_rnd,
  output logic signed [15:0] out_eq
);
  logic [15:0] cnt_ff;
  logic [15:0] lfsr_ff;
  logic [15:0] rnd_idx_ff;
  logic signed [15:0] min_ff, max_ff, rnd_ff, eq_ff;
  logic [31:0] prod;
  logic first, last;
  logic signed [15:0] nxt_min, nxt_max, nxt_rnd, nxt_eq;
  // ============================================================
  // pick selection
  assign prod = lfsr_ff * ratio;
  assign first = (cnt_ff == 16'h0000);
  assign last = (cnt_ff + 16'h0001 >= ratio);
  always_comb
  begin
    nxt_min = (first || in_data < min_ff) ? in_data : min_ff;
    nxt_max = (first || in_data > max_ff) ? in_data : max_ff;
    nxt_rnd = (cnt_ff == rnd_idx_ff) ? in_data : rnd_ff;
    nxt_eq = (cnt_ff == (ratio >> 1)) ? in_data : eq_ff;
  end
  // ============================================================
  // free-running generator
  always_ff @(posedge clk)
    if (!rstn)
      lfsr_ff <= `ACQ_LFSR_SEED;
    else
      lfsr_ff <= {1'b0, lfsr_ff[15:1]} ^ (lfsr_ff[0] ? `ACQ_LFSR_TAPS : 16'h0000);
  // ============================================================
  // region counting and capture
  always_ff @(posedge clk)
    if (!rstn)
    begin
      cnt_ff <= 16'h0000;
      rnd_idx_ff <= 16'h0000;
      min_ff <= 16'h0000;
      max_ff <= 16'h0000;
      rnd_ff <= 16'h0000;
      eq_ff <= 16'h0000;
    end
    else if (start)
    begin
      cnt_ff <= 16'h0000;
      rnd_idx_ff <= prod[31:16];
    end
    else if (in_valid)
    begin
      min_ff <= nxt_min;
      max_ff <= nxt_max;
      rnd_ff <= nxt_rnd;
      eq_ff <= nxt_eq;
      cnt_ff <= last ? 16'h0000 : cnt_ff + 16'h0001;
      if (last)
        rnd_idx_ff <= prod[31:16];
    end
  always_ff @(posedge clk)
    if (!rstn)
    begin
      out_valid <= 1'b0;
      out_min <= 16'h0000;
      out_max <= 16'h0000;
      out_rnd <= 16'h0000;
      out_eq <= 16'h0000;
    end
    else
    begin
      out_valid <= in_valid && last && !start;
      if (in_valid && last && !start)
      begin
        out_min <= nxt_min;
        out_max <= nxt_max;
        out_rnd <= nxt_rnd;
        out_eq <= nxt_eq;
      end
    end
endmodule

// ---- logic/acq_pkg.sv ----
// types of the acquisition decimation and completion block
package acq_pkg;
  typedef enum logic [2:0]
  {
    MODE_RT_NORMAL = 3'b000,
    MODE_EQUIV = 3'b001,
    MODE_PEAK = 3'b010,
    MODE_SEGMENTED = 3'b011,
    MODE_AVERAGE = 3'b100
  } acq_mode_type;
  typedef enum logic [1:0]
  {
    ST_CLEAR = 2'b01,
    ST_RUN = 2'b10
  } acq_state_type;
endpackage

// ---- logic/acq_region_avg.sv ----
// averaging decimator: one mean per data region
`timescale 1ns/1ps
`include "acq_defs.svh"
module acq_region_avg (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // sample stream
  input wire logic start,
  input wire logic in_valid,
  input wire logic signed [15:0] in_data,
  input wire logic [15:0] ratio,
  // region mean
  output logic out_valid,
  output logic signed [15:0] out_avg
);
  logic [15:0] cnt_ff;
  logic signed [31:0] sum_ff;
  logic signed [31:0] nxt_sum;
  logic signed [31:0] quot;
  logic last;
  // ============================================================
  // accumulate and divide
  assign last = (cnt_ff + 16'h0001 >= ratio);
  assign nxt_sum = ((cnt_ff == 16'h0000) ? 32'sh0 : sum_ff) + 32'(in_data);
  assign quot = nxt_sum / $signed({16'h0000, ratio});
  always_ff @(posedge clk)
    if (!rstn)
    begin
      cnt_ff <= 16'h0000;
      sum_ff <= 32'sh0;
    end
    else if (start)
      cnt_ff <= 16'h0000;
    else if (in_valid)
    begin
      sum_ff <= nxt_sum;
      cnt_ff <= last ? 16'h0000 : cnt_ff + 16'h0001;
    end
  always_ff @(posedge clk)
    if (!rstn)
    begin
      out_valid <= 1'b0;
      out_avg <= 16'h0000;
    end
    else
    begin
      out_valid <= in_valid && last && !start;
      if (in_valid && last && !start)
        out_avg <= quot[15:0];
    end
endmodule

// ---- sim/acq_host_model.sv ----
// host side model: drives the register port of the acquisition block
`timescale 1ns/1ps
module acq_host_model (
  // clock
  input wire logic clk,
  // register port
  output logic [3:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial
  begin
    reg_addr = 4'hF;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one write cycle, then a released bus shows inverted values
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    @(posedge clk);
  endtask
  // one read cycle; data is taken by the bench monitor
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
  endtask
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench of the acquisition completion block
`timescale 1ns/1ps
`include "acq_defs.svh"
module tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, store_valid, peak_valid, meas_req, record_complete, sinc_smoothing_enable;
  logic acq_trig = 1'b0, acq_cycle_end = 1'b0, single_run = 1'b0, smp_valid = 1'b0;
  logic signed [15:0] smp_data = 16'h0000;
  logic [7:0] smp_bucket = 8'h00;
  logic [7:0] store_addr, peak_addr;
  logic signed [15:0] store_data, peak_min, peak_max, peak_rnd, peak_eq;
  logic [15:0] lfsr = 16'h0037;
  logic rd_d = 1'b0;
  int num_errors = 0, samples_checked = 0, meas_cnt = 0, meas_exp = 0;
  logic [47:0] rq[$], pq[$], aq[$];
  logic [63:0] vq[$];
  logic [63:0] vt;
  logic pk_hit;
  always #20 clk = ~clk;
  acq_host_model u_acq_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));
  acq_completion_ctrl u_acq_completion_ctrl (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .acq_trig(acq_trig), .acq_cycle_end(acq_cycle_end), .single_run(single_run),
    .smp_valid(smp_valid), .smp_data(smp_data), .smp_bucket(smp_bucket),
    .store_valid(store_valid), .store_addr(store_addr), .store_data(store_data),
    .peak_valid(peak_valid), .peak_addr(peak_addr), .peak_min(peak_min), .peak_max(peak_max),
    .peak_rnd(peak_rnd), .peak_eq(peak_eq), .meas_req(meas_req),
    .record_complete(record_complete), .sinc_smoothing_enable(sinc_smoothing_enable));
  // ============================================================
  // helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    rq.push_back({16'h0000, e});
    u_acq_host_model.rd(a);
  endtask
  task automatic set_ctrl(input logic [31:0] c);
    u_acq_host_model.wr(`ACQ_ADDR_CTRL, c);
    settle(260);
  endtask
  task automatic cycle_end(input int inc);
    acq_cycle_end <= 1'b1;
    @(posedge clk);
    acq_cycle_end <= 1'b0;
    settle(3);
    meas_exp += inc;
    chk("meas_req count", meas_exp, meas_cnt);
  endtask
  task automatic burst(input logic [63:0] v);
    acq_trig <= 1'b1;
    @(posedge clk);
    acq_trig <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      smp_valid <= 1'b1;
      smp_data <= v[16*i+:16];
      smp_bucket <= 8'(i);
      @(posedge clk);
    end
    smp_valid <= 1'b0;
    settle(4);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ============================================================
  // monitor: compares outputs with the oldest note
  always @(posedge clk)
  begin
    rd_d <= reg_rd;
    if (meas_req === 1'b1)
      meas_cnt++;
    if (rd_d && rq.size() > 0)
      chk("reg_rdata", rq.pop_front(), {16'h0000, reg_rdata});
    if (peak_valid === 1'b1 && pq.size() > 0)
    begin
      vt = vq.pop_front();
      pk_hit = (peak_rnd === vt[15:0]) || (peak_rnd === vt[31:16]) || (peak_rnd === vt[47:32])
        || (peak_rnd === vt[63:48]);
      chk("peak column", pq.pop_front(), {peak_min, peak_max, peak_eq});
      chk("peak_addr", 48'h0, {40'h0, peak_addr});
      chk("peak_rnd pick", 48'h1, {47'h0, pk_hit});
    end
    if (store_valid === 1'b1 && aq.size() > 0)
      chk("store_data", aq.pop_front(), {24'h0, store_addr, store_data});
  end
  initial
  begin
    settle(20000);
    num_errors++;
    report_and_stop;
  end
  // ============================================================
  // main sequence
  initial
  begin
    logic [63:0] v;
    logic signed [15:0] lo, hi, s;
    settle(10);
    rstn <= 1'b1;
    settle(1);
    rd_chk(`ACQ_ADDR_PCT, 32'h5A);
    rd_chk(`ACQ_ADDR_CTRL, 32'h08);
    rd_chk(4'h7, 32'h0);
    u_acq_host_model.wr(`ACQ_ADDR_PCT, 32'h65);
    rd_chk(`ACQ_ADDR_PCT, 32'h5A);
    u_acq_host_model.wr(`ACQ_ADDR_PCT, 32'h0);
    rd_chk(`ACQ_ADDR_PCT, 32'h0);
    u_acq_host_model.wr(`ACQ_ADDR_CTRL, 32'h88);
    rd_chk(`ACQ_ADDR_PCT, 32'h64);
    rd_chk(`ACQ_ADDR_CTRL, 32'h08);
    $display("registers done");
    for (int m = 0; m < 5; m++)
    begin
      u_acq_host_model.wr(`ACQ_ADDR_CTRL, 32'h18 | m);
      chk("sinc", (m != 1 && m != 3), sinc_smoothing_enable);
      rd_chk(`ACQ_ADDR_ERAT, (m == 2 || m == 4) ? 32'h4 : 32'h1);
    end
    $display("modes done");
    set_ctrl(32'h08);
    cycle_end(1);
    set_ctrl(32'h09);
    cycle_end(0);
    set_ctrl(32'h01);
    single_run <= 1'b1;
    rd_chk(`ACQ_ADDR_STAT, 32'h3);
    cycle_end(0);
    single_run <= 1'b0;
    cycle_end(1);
    rd_chk(`ACQ_ADDR_STAT, 32'h1);
    set_ctrl(32'h09);
    u_acq_host_model.wr(`ACQ_ADDR_PCT, 32'h0);
    cycle_end(1);
    $display("completion done");
    set_ctrl(32'h0A);
    for (int k = 0; k < 3; k++)
    begin
      lo = 16'h7FFF;
      hi = 16'h8000;
      for (int i = 0; i < 4; i++)
      begin
        lfsr = lfsr_next(lfsr);
        s = lfsr;
        v[16*i+:16] = s;
        if (s < lo)
          lo = s;
        if (s > hi)
          hi = s;
      end
      pq.push_back({lo, hi, v[47:32]});
      vq.push_back(v);
      burst(v);
    end
    rd_chk(`ACQ_ADDR_STAT, 32'h2);
    set_ctrl(32'h0C);
    lfsr = lfsr_next(lfsr);
    s = {{3{lfsr[12]}}, lfsr[12:0]};
    aq.push_back({32'h0, s + 16'sh0002});
    burst({s + 16'sh0005, s + 16'sh0002, s + 16'sh0001, s});
    $display("decimation done");
    set_ctrl(32'h09);
    u_acq_host_model.wr(`ACQ_ADDR_RLEN, 32'h8);
    u_acq_host_model.wr(`ACQ_ADDR_PCT, 32'h32);
    cycle_end(0);
    for (int i = 0; i < 4; i++)
    begin
      lfsr = lfsr_next(lfsr);
      v[16*i+:16] = lfsr;
      aq.push_back({24'h0, 8'(i), lfsr});
    end
    burst(v);
    cycle_end(1);
    $display("equivalent done");
    chk("pending notes", 48'h0, rq.size() + pq.size() + aq.size() + vq.size());
    report_and_stop;
  end
endmodule
